//--- tpcg_pkg.sv
// How it works
// - One processor cycle spans nine oscillator periods.
// - A synchronous divide-by-nine counter feeds decode gating for all phase, strobe and sample timing.
// - Every phase width and delay is a whole number of oscillator periods.
// - A logic-level output copies phase two.
// - A half-rate toggled copy of the oscillator is driven out.
// - Cycle-start marker gated with phase one aux timing gives low status strobe.
// - During reset the status strobe is held low.
// - Reset request is registered on the phase two sample timing edge.
// - Reset output to the processor is active high.
// - Wait request is registered on phase two sample timing; ready comes from it.
package tpcg_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned DIVIDE_BY      = 9;
    localparam logic [3:0]  PH1_START      = 4'h0;
    localparam logic [3:0]  PH1_LEN        = 4'h2;
    localparam logic [3:0]  PH2_START      = 4'h2;
    localparam logic [3:0]  PH2_LEN        = 4'h5;
    // Status strobe slot: six periods after phase two rises.
    localparam logic [3:0]  STROBE_SLOT    = 4'h8;
    // Phase one aux timing marks the strobe slot window.
    localparam logic [3:0]  PH1A_SLOT      = 4'h8;
    // Phase two sample timing: last period of phase two.
    localparam logic [3:0]  PH2D_SLOT      = 4'h6;
    localparam logic [3:0]  CNT_RESET      = 4'h0;
    localparam logic [3:0]  CNT_LAST       = 4'h8;
endpackage : tpcg_pkg

//--- tpcg_divider.sv
`timescale 1ns/100ps
`default_nettype none
module tpcg_divider
    import tpcg_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // Count
    output logic      [3:0] o_count
);
    // Reset parks the count in the last both-low state, so the first
    // phase one after reset comes out at its full width.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_count <= CNT_LAST;
        end else if (o_count == CNT_LAST) begin
            o_count <= CNT_RESET;
        end else begin
            o_count <= o_count + 4'h1;
        end
    end

    a_count_range : assert property (
        @(posedge i_clk) disable iff (i_srst)
        o_count <= CNT_LAST
    ) else $error("divider left range");
endmodule : tpcg_divider
`default_nettype wire

//--- tpcg_clock_gen.sv
`timescale 1ns/100ps
`default_nettype none
module tpcg_clock_gen
    import tpcg_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // Processor and system inputs
    input  wire logic i_cycle_start,
    input  wire logic i_reset_request_in_n,
    input  wire logic i_wait_request_in,
    // Phase clocks
    output logic      o_phase1,
    output logic      o_phase2,
    output logic      o_phase2_ttl,
    output logic      o_osc_tick,
    // Status and control
    output logic      o_status_capture_strobe_n,
    output logic      o_reset,
    output logic      o_ready
);
    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    // Next state of the nine-state counter; the last state wraps to zero.
    function automatic logic [3:0] wrap_next(
        input logic [3:0] value
    );
        if (value == CNT_LAST) begin
            return CNT_RESET;
        end
        return value + 4'h1;
    endfunction : wrap_next

    // True while value lies in the run of len states that starts at start.
    function automatic logic in_window(
        input logic [3:0] value,
        input logic [3:0] start,
        input logic [3:0] len
    );
        return (value >= start) && (value < start + len);
    endfunction : in_window

    // ****************************************************************
    // Counter and decode
    // ****************************************************************
    logic [3:0] count;
    logic [3:0] next_count;
    wire        ph1_next;
    wire        ph2_next;
    wire        phase_one_aux_timing;
    wire        phase_two_sample_timing;
    wire        strobe_low;
    logic       marker_seen_q;

    tpcg_divider u_div (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .o_count (count)
    );

    // The phase outputs are registered, so the decode looks one state
    // ahead; this keeps every output glitch free at the cost of a
    // second incrementer beside the divider.
    assign next_count = wrap_next(count);
    assign ph1_next   = in_window(next_count, PH1_START,
                                  PH1_LEN);
    assign ph2_next   = in_window(next_count, PH2_START,
                                  PH2_LEN);

    // The aux timing marks the state in which the strobe is launched;
    // the strobe then sits in the last both-low state, once the
    // processor's status byte has settled on the bus.
    assign phase_one_aux_timing    = (next_count == PH1A_SLOT);

    // The sample timing is the last phase two state; inputs taken there
    // let ready and reset settle in the gap before phase one comes
    // round again.
    assign phase_two_sample_timing = (count == PH2D_SLOT);

    // A pending reset holds the strobe low as well, so the system
    // controller is reset together with the processor.
    assign strobe_low = o_reset ||
        (marker_seen_q && phase_one_aux_timing);

    // ****************************************************************
    // Phase clocks
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_phase1     <= 1'b0;
            o_phase2     <= 1'b0;
            o_phase2_ttl <= 1'b0;
        end else begin
            o_phase1     <= ph1_next;
            o_phase2     <= ph2_next;
            o_phase2_ttl <= ph2_next;
        end
    end

    // ****************************************************************
    // Oscillator copy
    // ****************************************************************
    // A flop can toggle only once per period, so this copy runs at half
    // the oscillator rate; logic that needs the full rate must take the
    // oscillator itself.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_osc_tick <= 1'b0;
        end else begin
            o_osc_tick <= ~o_osc_tick;
        end
    end

    // ****************************************************************
    // Sampled inputs
    // ****************************************************************
    // All three inputs are taken on one edge per processor cycle, so
    // ready and reset only ever move in the both-low gap.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            marker_seen_q <= 1'b0;
            o_reset       <= 1'b1;
            o_ready       <= 1'b0;
        end else if (phase_two_sample_timing) begin
            marker_seen_q <= i_cycle_start;
            o_reset       <= ~i_reset_request_in_n;
            o_ready       <= i_wait_request_in;
        end
    end

    // ****************************************************************
    // Status strobe
    // ****************************************************************
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_status_capture_strobe_n <= 1'b0;
        end else begin
            o_status_capture_strobe_n <= ~strobe_low;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_phase_overlap : assert property (
        @(posedge i_clk) disable iff (i_srst)
        !(o_phase1 && o_phase2)
    ) else $error("phases overlap");

    a_phase1_width : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $rose(o_phase1) |-> o_phase1 [*2] ##1 !o_phase1
    ) else $error("phase one width");

    a_phase2_width : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $rose(o_phase2) |-> o_phase2 [*5] ##1 !o_phase2
    ) else $error("phase two width");

    a_phase_handover : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $fell(o_phase1) |-> $rose(o_phase2)
    ) else $error("phase two not at phase one end");

    a_gap_width : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $fell(o_phase2) |-> !o_phase1 ##1 !o_phase1 ##1 o_phase1
    ) else $error("both low gap width");

    a_phase_period : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $rose(o_phase1) |-> ##9 $rose(o_phase1)
    ) else $error("period not nine");

    a_ttl_copy : assert property (
        @(posedge i_clk) disable iff (i_srst)
        o_phase2_ttl == o_phase2
    ) else $error("ttl copy differs");

    a_osc_toggle : assert property (
        @(posedge i_clk) disable iff (i_srst)
        !$past(i_srst) |-> o_osc_tick != $past(o_osc_tick)
    ) else $error("oscillator copy stalled");

    a_strobe_place : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $fell(o_status_capture_strobe_n) && !$past(o_reset) |->
            $past(o_phase2, 2) && !$past(o_phase2)
            ##1 o_status_capture_strobe_n
    ) else $error("strobe misplaced");

    a_strobe_marker : assert property (
        @(posedge i_clk) disable iff (i_srst)
        phase_two_sample_timing && i_cycle_start |->
            ##2 !o_status_capture_strobe_n
    ) else $error("strobe missing after marker");

    a_strobe_idle : assert property (
        @(posedge i_clk) disable iff (i_srst)
        !o_reset && !phase_one_aux_timing |=> o_status_capture_strobe_n
    ) else $error("strobe low outside its slot");

    a_strobe_reset : assert property (
        @(posedge i_clk) disable iff (i_srst)
        o_reset |=> !o_status_capture_strobe_n
    ) else $error("strobe high during reset");

    a_reset_timing : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $changed(o_reset) |-> $past(count) == PH2D_SLOT
    ) else $error("reset off edge");

    a_reset_value : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $past(phase_two_sample_timing) |->
            o_reset == !$past(i_reset_request_in_n)
    ) else $error("reset output wrong level");

    a_ready_timing : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $changed(o_ready) |-> $past(count) == PH2D_SLOT
    ) else $error("ready off edge");

    a_ready_value : assert property (
        @(posedge i_clk) disable iff (i_srst)
        $past(phase_two_sample_timing) |->
            o_ready == $past(i_wait_request_in)
    ) else $error("ready output wrong level");
endmodule : tpcg_clock_gen
`default_nettype wire

//--- tpcg_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module tpcg_cpu_model (
    // Clock and timing
    input  wire logic i_clk,
    input  wire logic i_phase2,
    input  wire logic i_phase2_ttl,
    // Machine cycle request and marker
    input  wire logic i_new_cycle,
    output logic      o_cycle_start,
    // Bus hand-over to an outside requester
    input  wire logic i_hold_request,
    output logic      o_bus_gate
);
    logic hold_grant_q;

    // The marker rides on phase two, so it is gone before the next cycle.
    always_ff @(posedge i_clk) begin
        o_cycle_start <= i_new_cycle & i_phase2;
        hold_grant_q  <= i_hold_request;
    end

    // An outside requester reaches the bus only inside the phase two
    // copy, and only once hold has been granted.
    assign o_bus_gate = hold_grant_q & i_phase2_ttl;
endmodule : tpcg_cpu_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import tpcg_pkg::*;
    logic clk = 0, srst = 1, req_n = 0, wait_in = 1, go = 0, hold = 0, sync;
    logic p1, p2, ttl, osc, stb_n, rst, rdy, osc_l, prev, gate;
    int   error_cnt = 0, check_count = 0, cyc = 0;
    always #25 clk = ~clk;
    tpcg_clock_gen dut (.i_clk(clk), .i_srst(srst), .i_cycle_start(sync),
        .i_reset_request_in_n(req_n), .i_wait_request_in(wait_in),
        .o_phase1(p1), .o_phase2(p2), .o_phase2_ttl(ttl), .o_osc_tick(osc),
        .o_status_capture_strobe_n(stb_n), .o_reset(rst), .o_ready(rdy));
    tpcg_cpu_model cpu (.i_clk(clk), .i_phase2(p2), .i_phase2_ttl(ttl),
        .i_new_cycle(go), .o_cycle_start(sync), .i_hold_request(hold),
        .o_bus_gate(gate));
    task automatic check(input string nm, input logic seen, input logic exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", nm, exp, seen);
        end
    endtask : check
    task automatic finish_test;
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // The run needs about 400 cycles; a stalled phase two ends it here.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        void'($urandom(32'hf822));
        repeat (16) @(negedge clk);
        check("reset in reset", rst, 1'b1);
        check("strobe in reset", stb_n, 1'b0);
        check("phase one in reset", p1, 1'b0);
        srst = 0;
        @(posedge p2);
        // Request held low across release, so reset stays high until then.
        for (int i = 0; i < 40; i++) begin
            for (int k = 0; k < 9; k++) begin
                // Every look is on a falling edge, clear of output changes.
                @(negedge clk);
                if (k == 0) begin
                    prev = !req_n;
                    req_n = (i < 3) ? 1'b0 : 1'($urandom);
                    wait_in = 1'($urandom);
                    go = 1'($urandom);
                    hold = 1'($urandom);
                end
                check("phase two", p2, k < 5);
                check("phase one", p1, k > 6);
                check("phase two copy", ttl, k < 5);
                if (i + k > 0) check("oscillator", osc, !osc_l);
                osc_l = osc;
                if (k > 0) check("bus gate", gate, hold && k < 5);
                check("strobe", stb_n, !((k == 6 && go) ||
                    (k < 6 ? prev : !req_n)));
            end
            check("reset out", rst, !req_n);
            check("ready", rdy, wait_in);
        end
        finish_test();
    end
endmodule : testbench
`default_nettype wire
